// ### hw/cg_regs.vh
`ifndef CG_REGS_VH
`define CG_REGS_VH

// register byte offsets
`define CG_ADDR_W 8
`define CG_OFF_PERIPH_EN 8'h10
`define CG_OFF_PERIPH_DIS 8'h14
`define CG_OFF_PERIPH_STATE 8'h18
`define CG_OFF_OSC_CTRL 8'h20
`define CG_OFF_FREQ_MEAS 8'h24
`define CG_OFF_PLL_A 8'h28
`define CG_OFF_PLL_B 8'h2c
`define CG_OFF_MASTER 8'h30
`define CG_OFF_STATUS 8'h68

// reset values
`define CG_RST_PERIPH 32'h0000_0000
`define CG_RST_OSC 32'h0000_0000
`define CG_RST_PLL 32'h0000_3f00
`define CG_RST_MASTER 32'h0000_0000

// writable masks, reserved bits stay zero
`define CG_MASK_PERIPH 32'hffff_fffc
`define CG_MASK_OSC 32'h0000_ff01
`define CG_MASK_PLL_A 32'h07ff_ffff
`define CG_MASK_PLL_B 32'h17ff_ffff
`define CG_MASK_MASTER 32'h0000_031f
`define CG_PERIPH_LO 2
`define CG_PERIPH_HI 31

// field positions
`define CG_OSC_EN_BIT 0
`define CG_OSC_CNT_HI 15
`define CG_OSC_CNT_LO 8
`define CG_FREQ_VALID_BIT 16
`define CG_PLL_DIV_HI 7
`define CG_PLL_DIV_LO 0
`define CG_PLL_CNT_HI 13
`define CG_PLL_CNT_LO 8
`define CG_PLL_RANGE_HI 15
`define CG_PLL_RANGE_LO 14
`define CG_PLL_MUL_HI 26
`define CG_PLL_MUL_LO 16
`define CG_PLL_USB_BIT 28
`define CG_MCK_SRC_HI 1
`define CG_MCK_SRC_LO 0
`define CG_MCK_MASTER_DIVIDE_POWER_HI 4
`define CG_MCK_MASTER_DIVIDE_POWER_LO 2
`define CG_MCK_RATIO_HI 9
`define CG_MCK_RATIO_LO 8
`define CG_ST_OSC_BIT 0
`define CG_ST_LOCK_A_BIT 1
`define CG_ST_LOCK_B_BIT 2

// source codes
`define CG_SRC_SLOW 2'h0
`define CG_SRC_MAIN 2'h1
`define CG_SRC_PLL_A 2'h2
`define CG_SRC_PLL_B 2'h3

// frequency measurement
`define CG_MEAS_SLOW_PERIODS 4'hf
`define CG_FREQ_MAX 16'hffff

`endif

// ### hw/cg_slow_timer.v
`timescale 1ns/1ps
`default_nettype none

// counts slow clock ticks after a restart, then raises done
module cg_slow_timer (
    // clock and reset
    input wire clk_in,
    input wire reset_in,
    // control
    input wire restart_in,
    input wire abort_in,
    input wire slow_tick_in,
    input wire [7:0] count_in,
    // result
    output reg done_out
);

reg running_reg;
reg [7:0] remain_reg;

always @(posedge clk_in) begin
    if (reset_in) begin
        running_reg <= 1'b0;
        remain_reg <= 8'h00;
        done_out <= 1'b0;
    end else if (abort_in) begin
        running_reg <= 1'b0;
        remain_reg <= 8'h00;
        done_out <= 1'b0;
    end else if (restart_in) begin
        running_reg <= 1'b1;
        remain_reg <= count_in;
        done_out <= 1'b0;
    end else if (running_reg) begin
        if (remain_reg == 8'h00) begin
            running_reg <= 1'b0;
            done_out <= 1'b1;
        end else if (slow_tick_in) begin
            remain_reg <= remain_reg - 8'h01;
        end
    end
end

endmodule

`default_nettype wire

// ### hw/cg_freq_meter.v
`timescale 1ns/1ps
`default_nettype none
`include "cg_regs.vh"

// counts main ticks over a window of slow clock periods
module cg_freq_meter (
    // clock and reset
    input wire clk_in,
    input wire reset_in,
    // inputs
    input wire enable_in,
    input wire slow_tick_in,
    input wire main_tick_in,
    // result
    output reg [15:0] count_out,
    output reg valid_out
);

reg armed_reg;
reg [3:0] periods_reg;
reg [15:0] acc_reg;

always @(posedge clk_in) begin
    if (reset_in || !enable_in) begin
        armed_reg <= 1'b0;
        periods_reg <= 4'h0;
        acc_reg <= 16'h0000;
        count_out <= 16'h0000;
        valid_out <= 1'b0;
    end else if (!armed_reg) begin
        // window must open on a slow clock edge
        armed_reg <= slow_tick_in;
    end else begin
        if (slow_tick_in && periods_reg == `CG_MEAS_SLOW_PERIODS) begin
            count_out <= acc_reg;
            valid_out <= 1'b1;
            periods_reg <= 4'h0;
            acc_reg <= main_tick_in ? 16'h0001 : 16'h0000;
        end else begin
            if (slow_tick_in)
                periods_reg <= periods_reg + 4'h1;
            if (main_tick_in && acc_reg != `CG_FREQ_MAX)
                acc_reg <= acc_reg + 16'h0001;
        end
    end
end

endmodule

`default_nettype wire

// ### hw/cg_clock_gen.v
//
// Notes on behaviour
// - enable register write of one starts peripheral clocks 2 to 31
// - disable register write of one stops peripheral clocks
// - state register shows which peripheral clocks run
// - oscillator enable off: pin clock used; on: crystal oscillator runs
// - bits 15:8 give oscillator start-up length in slow cycles
// - main cycles over 16 slow periods read in the frequency field
// - bit 16 valid only with oscillator enabled and count ready
// - first divider: 0 stops, 1 bypasses, 2..255 divides main clock
// - first lock flag set lock-count slow cycles after register write
// - first range: 00 low band, 10 high band, others reserved
// - first multiplier zero stops the PLL, else multiplies by n+1
// - second divider: 0 stops, 1 bypasses, 2..255 divides
// - second lock flag set lock-count slow cycles after write
// - second range: 00 low band, 10 high band, others reserved
// - second multiplier zero stops the PLL, else multiplies by n+1
// - bit 28 feeds USB the second PLL clock direct or halved
// - master source: slow, main, first PLL, second PLL
// - prescaler divides source by two to the field, 111 reserved
// - processor runs one to four times the master clock
// - status register shows one lock flag per PLL
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cg_regs.vh"

module cg_clock_gen (
    // clock and reset
    input wire clk_in,
    input wire reset_in,
    // register port
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    // clock rate pulses
    input wire slow_tick_in,
    input wire main_tick_in,
    input wire pll_a_tick_in,
    input wire pll_b_tick_in,
    // peripheral gating
    output reg [31:0] peripheral_clock_bits_out,
    // oscillator
    output reg oscillator_enable_out,
    // first pll
    output reg first_pll_ref_tick_out,
    output reg [10:0] first_pll_multiplier_out,
    output reg [1:0] first_pll_range_out,
    output reg first_pll_active_out,
    output reg first_pll_locked_out,
    // second pll
    output reg second_pll_ref_tick_out,
    output reg [10:0] second_pll_multiplier_out,
    output reg [1:0] second_pll_range_out,
    output reg second_pll_active_out,
    output reg second_pll_locked_out,
    // derived clocks
    output reg usb_tick_out,
    output reg master_tick_out,
    output reg cpu_tick_out
);

// true when a divider counter has reached its last step
function div_last;
    input [7:0] cnt;
    input [7:0] div;
    begin
        div_last = (div <= 8'h01) || (cnt >= div - 8'h01);
    end
endfunction

// low bits of prescaler counter that must all be one
function [6:0] master_divide_power_mask;
    input [2:0] master_divide_power;
    begin
        master_divide_power_mask = (7'h01 << master_divide_power) - 7'h01;
    end
endfunction

reg [31:0] periph_reg;
reg [31:0] osc_reg;
reg [31:0] pll_a_reg;
reg [31:0] pll_b_reg;
reg [31:0] master_reg;
reg [7:0] div_a_cnt_reg;
reg [7:0] div_b_cnt_reg;
reg [6:0] master_divide_power_cnt_reg;
reg [1:0] ratio_cnt_reg;
reg usb_half_reg;
reg [31:0] rdata_next;
reg src_tick;
reg cpu_tick_next;
reg master_tick_next;

wire wr_periph_en = wr_in && addr_in == `CG_OFF_PERIPH_EN;
wire wr_periph_dis = wr_in && addr_in == `CG_OFF_PERIPH_DIS;
wire wr_osc = wr_in && addr_in == `CG_OFF_OSC_CTRL;
wire wr_pll_a = wr_in && addr_in == `CG_OFF_PLL_A;
wire wr_pll_b = wr_in && addr_in == `CG_OFF_PLL_B;
wire wr_master = wr_in && addr_in == `CG_OFF_MASTER;

wire osc_en = osc_reg[`CG_OSC_EN_BIT];
wire [7:0] div_a = pll_a_reg[`CG_PLL_DIV_HI:`CG_PLL_DIV_LO];
wire [7:0] div_b = pll_b_reg[`CG_PLL_DIV_HI:`CG_PLL_DIV_LO];
wire [10:0] mul_a = pll_a_reg[`CG_PLL_MUL_HI:`CG_PLL_MUL_LO];
wire [10:0] mul_b = pll_b_reg[`CG_PLL_MUL_HI:`CG_PLL_MUL_LO];
wire usb_halve_select = pll_b_reg[`CG_PLL_USB_BIT];
wire [1:0] mck_src = master_reg[`CG_MCK_SRC_HI:`CG_MCK_SRC_LO];
wire [2:0] mck_master_divide_power = master_reg[`CG_MCK_MASTER_DIVIDE_POWER_HI:`CG_MCK_MASTER_DIVIDE_POWER_LO];
wire [1:0] cpu_to_bus_ratio = master_reg[`CG_MCK_RATIO_HI:`CG_MCK_RATIO_LO];
wire pll_a_on = mul_a != 11'h000 && div_a != 8'h00;
wire pll_b_on = mul_b != 11'h000 && div_b != 8'h00;

wire osc_stable;
wire lock_a;
wire lock_b;
wire [15:0] main_freq_count;
wire main_count_valid;

// reset and writable masks as vectors so each bit can be picked
localparam [31:0] PERIPH_RST = `CG_RST_PERIPH;
localparam [31:0] PERIPH_MASK = `CG_MASK_PERIPH;

// peripheral gating bits, set and clear by separate writes
genvar gi;
generate
    for (gi = 0; gi <= `CG_PERIPH_HI; gi = gi + 1) begin : g_periph
        // bits outside the mask name no peripheral and stay low
        always @(posedge clk_in) begin
            if (reset_in || !PERIPH_MASK[gi])
                periph_reg[gi] <= PERIPH_RST[gi] & PERIPH_MASK[gi];
            else if (wr_periph_en && wdata_in[gi])
                periph_reg[gi] <= 1'b1;
            else if (wr_periph_dis && wdata_in[gi])
                periph_reg[gi] <= 1'b0;
        end
    end
endgenerate

// configuration registers, reserved bits masked off
always @(posedge clk_in) begin
    if (reset_in) begin
        osc_reg <= `CG_RST_OSC;
        pll_a_reg <= `CG_RST_PLL;
        pll_b_reg <= `CG_RST_PLL;
        master_reg <= `CG_RST_MASTER;
    end else begin
        if (wr_osc)
            osc_reg <= wdata_in & `CG_MASK_OSC;
        if (wr_pll_a)
            pll_a_reg <= wdata_in & `CG_MASK_PLL_A;
        if (wr_pll_b)
            pll_b_reg <= wdata_in & `CG_MASK_PLL_B;
        // rewriting the same value still restarts the prescaler and ratio counters
        if (wr_master)
            master_reg <= wdata_in & `CG_MASK_MASTER;
    end
end

// oscillator start-up, restarted by each write that enables it
cg_slow_timer u_osc_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .restart_in(wr_osc && wdata_in[`CG_OSC_EN_BIT]),
    .abort_in(!osc_en && !wr_osc),
    .slow_tick_in(slow_tick_in),
    .count_in(wdata_in[`CG_OSC_CNT_HI:`CG_OSC_CNT_LO]),
    .done_out(osc_stable)
);

// count is loaded from the written data so it applies at once
cg_slow_timer u_lock_a (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .restart_in(wr_pll_a),
    .abort_in(1'b0),
    .slow_tick_in(slow_tick_in),
    .count_in({2'h0, wdata_in[`CG_PLL_CNT_HI:`CG_PLL_CNT_LO]}),
    .done_out(lock_a)
);

cg_slow_timer u_lock_b (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .restart_in(wr_pll_b),
    .abort_in(1'b0),
    .slow_tick_in(slow_tick_in),
    .count_in({2'h0, wdata_in[`CG_PLL_CNT_HI:`CG_PLL_CNT_LO]}),
    .done_out(lock_b)
);

// measurement only runs once the oscillator has settled
cg_freq_meter u_meter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(osc_en && osc_stable),
    .slow_tick_in(slow_tick_in),
    .main_tick_in(main_tick_in),
    .count_out(main_freq_count),
    .valid_out(main_count_valid)
);

// pll reference dividers, restarted on reprogramming
always @(posedge clk_in) begin
    if (reset_in || wr_pll_a) begin
        div_a_cnt_reg <= 8'h00;
        first_pll_ref_tick_out <= 1'b0;
    end else begin
        // divider zero gives no output at all
        first_pll_ref_tick_out <= main_tick_in && div_a != 8'h00 &&
            div_last(div_a_cnt_reg, div_a);
        if (main_tick_in)
            div_a_cnt_reg <= div_last(div_a_cnt_reg, div_a) ?
                8'h00 : div_a_cnt_reg + 8'h01;
    end
end

always @(posedge clk_in) begin
    if (reset_in || wr_pll_b) begin
        div_b_cnt_reg <= 8'h00;
        second_pll_ref_tick_out <= 1'b0;
    end else begin
        second_pll_ref_tick_out <= main_tick_in && div_b != 8'h00 &&
            div_last(div_b_cnt_reg, div_b);
        if (main_tick_in)
            div_b_cnt_reg <= div_last(div_b_cnt_reg, div_b) ?
                8'h00 : div_b_cnt_reg + 8'h01;
    end
end

// registered oscillator, pll and peripheral gating control outputs
always @(posedge clk_in) begin
    if (reset_in) begin
        oscillator_enable_out <= 1'b0;
        first_pll_multiplier_out <= 11'h000;
        first_pll_range_out <= 2'h0;
        first_pll_active_out <= 1'b0;
        first_pll_locked_out <= 1'b0;
        second_pll_multiplier_out <= 11'h000;
        second_pll_range_out <= 2'h0;
        second_pll_active_out <= 1'b0;
        second_pll_locked_out <= 1'b0;
        peripheral_clock_bits_out <= 32'h0000_0000;
    end else begin
        oscillator_enable_out <= osc_en;
        first_pll_multiplier_out <= mul_a;
        // reserved codes pass unchanged; software must avoid them
        first_pll_range_out <= pll_a_reg[`CG_PLL_RANGE_HI:`CG_PLL_RANGE_LO];
        first_pll_active_out <= pll_a_on;
        first_pll_locked_out <= lock_a;
        second_pll_multiplier_out <= mul_b;
        second_pll_range_out <= pll_b_reg[`CG_PLL_RANGE_HI:`CG_PLL_RANGE_LO];
        second_pll_active_out <= pll_b_on;
        second_pll_locked_out <= lock_b;
        peripheral_clock_bits_out <= periph_reg;
    end
end

// usb clock, optionally halved from the second pll
always @(posedge clk_in) begin
    if (reset_in) begin
        usb_half_reg <= 1'b0;
        usb_tick_out <= 1'b0;
    end else begin
        if (pll_b_tick_in && pll_b_on)
            usb_half_reg <= ~usb_half_reg;
        usb_tick_out <= pll_b_tick_in && pll_b_on &&
            (!usb_halve_select || usb_half_reg);
    end
end

// master source select
always @* begin
    case (mck_src)
        `CG_SRC_SLOW: src_tick = slow_tick_in;
        `CG_SRC_MAIN: src_tick = main_tick_in;
        `CG_SRC_PLL_A: src_tick = pll_a_tick_in && pll_a_on;
        `CG_SRC_PLL_B: src_tick = pll_b_tick_in && pll_b_on;
        default: src_tick = 1'b0;
    endcase
end

// prescaler gives the processor rate, master is a further 1..4 division
always @* begin
    cpu_tick_next = src_tick &&
        ((master_divide_power_cnt_reg & master_divide_power_mask(mck_master_divide_power)) == master_divide_power_mask(mck_master_divide_power));
    master_tick_next = cpu_tick_next &&
        ratio_cnt_reg == cpu_to_bus_ratio;
end

always @(posedge clk_in) begin
    if (reset_in || wr_master) begin
        master_divide_power_cnt_reg <= 7'h00;
        ratio_cnt_reg <= 2'h0;
        cpu_tick_out <= 1'b0;
        master_tick_out <= 1'b0;
    end else begin
        if (src_tick)
            master_divide_power_cnt_reg <= master_divide_power_cnt_reg + 7'h01;
        if (cpu_tick_next)
            ratio_cnt_reg <= master_tick_next ? 2'h0 : ratio_cnt_reg + 2'h1;
        cpu_tick_out <= cpu_tick_next;
        master_tick_out <= master_tick_next;
    end
end

// register read mux, data one cycle after the strobe
always @* begin
    case (addr_in)
        `CG_OFF_PERIPH_STATE: rdata_next = periph_reg & `CG_MASK_PERIPH;
        `CG_OFF_OSC_CTRL: rdata_next = osc_reg;
        `CG_OFF_FREQ_MEAS:
            rdata_next = {15'h0000, main_count_valid && osc_en,
                main_freq_count};
        `CG_OFF_PLL_A: rdata_next = pll_a_reg;
        `CG_OFF_PLL_B: rdata_next = pll_b_reg;
        `CG_OFF_MASTER: rdata_next = master_reg;
        `CG_OFF_STATUS:
            rdata_next = {29'h0000_0000, lock_b, lock_a, osc_stable};
        default: rdata_next = 32'h0000_0000;
    endcase
end

always @(posedge clk_in) begin
    if (reset_in)
        rdata_out <= 32'h0000_0000;
    else if (rd_in)
        rdata_out <= rdata_next;
    else
        rdata_out <= 32'h0000_0000;
end

endmodule

`default_nettype wire

// ### bench/cg_clock_gen_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "cg_regs.vh"
module cg_clock_gen_checker (
    // clock and reset
    input wire clk_in,
    input wire reset_in,
    // register port
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    // observed outputs and ticks
    input wire main_tick_in,
    input wire pll_b_tick_in,
    input wire [31:0] peripheral_clock_bits_out,
    input wire oscillator_enable_out,
    input wire first_pll_ref_tick_out,
    input wire [10:0] first_pll_multiplier_out,
    input wire [1:0] first_pll_range_out,
    input wire first_pll_active_out,
    input wire first_pll_locked_out,
    input wire second_pll_ref_tick_out,
    input wire [10:0] second_pll_multiplier_out,
    input wire [1:0] second_pll_range_out,
    input wire second_pll_active_out,
    input wire second_pll_locked_out,
    input wire usb_tick_out,
    input wire master_tick_out,
    input wire cpu_tick_out
);
    logic [31:0] wd1_reg;
    logic [31:0] wd2_reg;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // write data of two edges back, to compare fields
    always @(posedge clk_in) begin
        wd1_reg <= wdata_in;
        wd2_reg <= wd1_reg;
    end
    sequence wr_s(logic [7:0] a);
        wr_in && addr_in == a;
    endsequence
    // a write not followed by a competing write
    sequence wr_then_s(logic [7:0] a, logic [7:0] b);
        wr_s(a) ##1 !(wr_in && addr_in == b);
    endsequence
    low_bits_zero_a: assert property (
        peripheral_clock_bits_out[1:0] == 2'h0) else $error("low bits set");
    periph_set_a: assert property (
        wr_then_s(`CG_OFF_PERIPH_EN, `CG_OFF_PERIPH_DIS) |=>
        (peripheral_clock_bits_out & wd2_reg & `CG_MASK_PERIPH) ==
        (wd2_reg & `CG_MASK_PERIPH)) else $error("enable lost");
    periph_clr_a: assert property (
        wr_then_s(`CG_OFF_PERIPH_DIS, `CG_OFF_PERIPH_EN) |=>
        (peripheral_clock_bits_out & wd2_reg) == 32'h0)
        else $error("disable lost");
    wo_read_zero_a: assert property (
        rd_in && (addr_in == `CG_OFF_PERIPH_EN || addr_in == 8'h00) |=>
        rdata_out == 32'h0) else $error("write-only read nonzero");
    osc_follow_a: assert property (
        wr_then_s(`CG_OFF_OSC_CTRL, `CG_OFF_OSC_CTRL) |=>
        oscillator_enable_out == wd2_reg[0]) else $error("osc enable");
    mult_follow_a: assert property (
        wr_then_s(`CG_OFF_PLL_A, `CG_OFF_PLL_A) |=>
        first_pll_multiplier_out == wd2_reg[26:16]) else $error("mult");
    mult_zero_off_a: assert property (
        first_pll_multiplier_out == 11'h0 |-> !first_pll_active_out)
        else $error("pll active with zero mult");
    lock_a_drop_a: assert property (
        wr_s(`CG_OFF_PLL_A) |-> ##2 !first_pll_locked_out)
        else $error("lock a held");
    lock_b_drop_a: assert property (
        wr_s(`CG_OFF_PLL_B) |-> ##2 !second_pll_locked_out)
        else $error("lock b held");
    ref_cause_a: assert property (
        first_pll_ref_tick_out |-> $past(main_tick_in))
        else $error("ref tick uncaused");
    usb_cause_a: assert property (
        usb_tick_out |-> $past(pll_b_tick_in)) else $error("usb uncaused");
    master_on_cpu_a: assert property (
        master_tick_out |-> cpu_tick_out) else $error("master off cpu");
    range_a_follow_a: assert property (
        wr_then_s(`CG_OFF_PLL_A, `CG_OFF_PLL_A) |=>
        first_pll_range_out == wd2_reg[15:14]) else $error("range a");
    range_b_follow_a: assert property (
        wr_then_s(`CG_OFF_PLL_B, `CG_OFF_PLL_B) |=>
        second_pll_range_out == wd2_reg[15:14]) else $error("range b");
    mult_b_follow_a: assert property (
        wr_then_s(`CG_OFF_PLL_B, `CG_OFF_PLL_B) |=>
        second_pll_multiplier_out == wd2_reg[26:16]) else $error("mult b");
    mult_b_zero_off_a: assert property (
        second_pll_multiplier_out == 11'h0 |-> !second_pll_active_out)
        else $error("pll b active with zero mult");
    ref_b_cause_a: assert property (
        second_pll_ref_tick_out |-> $past(main_tick_in))
        else $error("ref b tick uncaused");
endmodule
bind cg_clock_gen cg_clock_gen_checker i_cg_clock_gen_checker (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .main_tick_in(main_tick_in),
    .pll_b_tick_in(pll_b_tick_in),
    .peripheral_clock_bits_out(peripheral_clock_bits_out),
    .oscillator_enable_out(oscillator_enable_out),
    .first_pll_ref_tick_out(first_pll_ref_tick_out),
    .first_pll_multiplier_out(first_pll_multiplier_out),
    .first_pll_active_out(first_pll_active_out),
    .first_pll_range_out(first_pll_range_out),
    .second_pll_ref_tick_out(second_pll_ref_tick_out),
    .second_pll_multiplier_out(second_pll_multiplier_out),
    .second_pll_range_out(second_pll_range_out),
    .second_pll_active_out(second_pll_active_out),
    .first_pll_locked_out(first_pll_locked_out),
    .second_pll_locked_out(second_pll_locked_out),
    .usb_tick_out(usb_tick_out), .master_tick_out(master_tick_out),
    .cpu_tick_out(cpu_tick_out));
`default_nettype wire

// ### bench/cg_clock_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cg_regs.vh"
module cg_clock_gen_tb_top;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic slow_tick_in = 1'b0;
    logic main_tick_in = 1'b0;
    logic pll_a_tick_in = 1'b0;
    logic pll_b_tick_in = 1'b0;
    logic [31:0] cyc = 32'h0;
    logic rd_seen = 1'b0;
    wire [31:0] rdata_out;
    wire first_pll_ref_tick_out;
    wire usb_tick_out;
    wire master_tick_out;
    wire cpu_tick_out;
    integer n_fail = 0;
    integer total_checks = 0;
    integer seed = 30218;
    integer nc, nm, nr, nu;
    logic [31:0] exp_q[$];
    logic [7:0] ra [4] = '{`CG_OFF_OSC_CTRL, `CG_OFF_PLL_A, `CG_OFF_PLL_B,
        `CG_OFF_MASTER};
    logic [31:0] rm [4] = '{`CG_MASK_OSC, `CG_MASK_PLL_A, `CG_MASK_PLL_B,
        `CG_MASK_MASTER};
    cg_clock_gen i_cg_clock_gen (
        .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .slow_tick_in(slow_tick_in),
        .main_tick_in(main_tick_in), .pll_a_tick_in(pll_a_tick_in),
        .pll_b_tick_in(pll_b_tick_in), .peripheral_clock_bits_out(),
        .oscillator_enable_out(), .first_pll_ref_tick_out(first_pll_ref_tick_out),
        .first_pll_multiplier_out(), .first_pll_range_out(),
        .first_pll_active_out(), .first_pll_locked_out(),
        .second_pll_ref_tick_out(), .second_pll_multiplier_out(),
        .second_pll_range_out(), .second_pll_active_out(),
        .second_pll_locked_out(), .usb_tick_out(usb_tick_out),
        .master_tick_out(master_tick_out), .cpu_tick_out(cpu_tick_out));
    always #2.5 clk_in = ~clk_in;
    // slow and main ticks never share a cycle, so window edges are exact
    always @(posedge clk_in) begin
        cyc <= cyc + 32'h1;
        slow_tick_in <= cyc[2:0] == 3'h0;
        main_tick_in <= cyc[0];
        pll_a_tick_in <= 1'b1;
        pll_b_tick_in <= cyc[1:0] == 2'h2;
    end
    task automatic check_word(input logic [31:0] got, input logic [31:0] e);
        total_checks = total_checks + 1;
        if (got !== e) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    // tick counts over a window may be off by one at the edges
    task automatic check_rate(input integer got, input integer e);
        total_checks = total_checks + 1;
        if (got > e + 1 || got < e - 1) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    always @(posedge clk_in) begin
        rd_seen <= rd_in;
        if (rd_seen) check_word(rdata_out, exp_q.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        rd_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        exp_q.push_back(e);
        addr_in <= a;
        wr_in <= 1'b0;
        rd_in <= 1'b1;
    endtask
    task automatic idle(input integer n);
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask
    task automatic measure;
        nc = 0;
        nm = 0;
        nr = 0;
        nu = 0;
        repeat (512) begin
            @(posedge clk_in);
            nc = nc + (cpu_tick_out === 1'b1);
            nm = nm + (master_tick_out === 1'b1);
            nr = nr + (first_pll_ref_tick_out === 1'b1);
            nu = nu + (usb_tick_out === 1'b1);
        end
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin : main
        logic [31:0] pm, d;
        integer k, s, p, r, base;
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(`CG_OFF_PERIPH_STATE, `CG_RST_PERIPH);
        rd(`CG_OFF_OSC_CTRL, `CG_RST_OSC);
        rd(`CG_OFF_PLL_A, `CG_RST_PLL);
        rd(`CG_OFF_PLL_B, `CG_RST_PLL);
        rd(`CG_OFF_MASTER, `CG_RST_MASTER);
        rd(`CG_OFF_STATUS, 32'h0);
        rd(`CG_OFF_PERIPH_EN, 32'h0);
        rd(8'h00, 32'h0);
        wr(`CG_OFF_FREQ_MEAS, $random(seed));
        rd(`CG_OFF_FREQ_MEAS, 32'h0);
        wr(`CG_OFF_PERIPH_EN, 32'hffff_ffff);
        rd(`CG_OFF_PERIPH_STATE, 32'hffff_fffc);
        wr(`CG_OFF_PERIPH_DIS, 32'hffff_ffff);
        rd(`CG_OFF_PERIPH_STATE, 32'h0);
        pm = 32'h0;
        for (k = 0; k < 6; k++) begin
            d = $random(seed);
            wr(`CG_OFF_PERIPH_EN, d);
            pm = pm | (d & `CG_MASK_PERIPH);
            wr(`CG_OFF_PERIPH_STATE, $random(seed));
            rd(`CG_OFF_PERIPH_STATE, pm);
            d = $random(seed);
            wr(`CG_OFF_PERIPH_DIS, d);
            pm = pm & ~d;
            rd(`CG_OFF_PERIPH_STATE, pm);
        end
        for (k = 0; k < 4; k++) begin
            d = $random(seed);
            if (k == 3) d[4:2] = 3'h7;
            wr(ra[k], d);
            rd(ra[k], d & rm[k]);
        end
        wr(`CG_OFF_OSC_CTRL, 32'h0);
        wr(`CG_OFF_PLL_A, 32'h0005_0301);
        wr(`CG_OFF_PLL_B, 32'h0005_0301);
        idle(1);
        rd(`CG_OFF_STATUS, 32'h0);
        idle(60);
        rd(`CG_OFF_STATUS, 32'h6);
        rd(`CG_OFF_FREQ_MEAS, 32'h0);
        wr(`CG_OFF_OSC_CTRL, 32'h0000_0201);
        idle(1);
        rd(`CG_OFF_STATUS, 32'h6);
        idle(400);
        rd(`CG_OFF_FREQ_MEAS, 32'h0001_0040);
        rd(`CG_OFF_STATUS, 32'h7);
        wr(`CG_OFF_OSC_CTRL, 32'h0000_0200);
        idle(2);
        rd(`CG_OFF_FREQ_MEAS, 32'h0);
        // each master value differs from the one before it
        for (k = 0; k < 12; k++) begin
            s = k / 3;
            p = (k % 3 == 2) ? 6 : k % 3;
            r = k % 4;
            wr(`CG_OFF_MASTER, (r << 8) | (p << 2) | s);
            idle(8);
            measure;
            base = (s == 0) ? 64 : (s == 1) ? 256 : (s == 2) ? 512 : 128;
            check_rate(nc, base >> p);
            check_rate(nm, (base >> p) / (r + 1));
        end
        for (k = 0; k < 3; k++) begin
            d = (k == 2) ? 3 : k;
            wr(`CG_OFF_PLL_A, 32'h0005_0100 | d);
            wr(`CG_OFF_PLL_B, 32'h0005_0101 | (k[0] << 28));
            idle(8);
            measure;
            check_rate(nr, (k == 0) ? 0 : 256 / d);
            check_rate(nu, 128 >> k[0]);
        end
        idle(2);
        for (k = 0; k < 10 && exp_q.size() != 0; k++) @(posedge clk_in);
        if (exp_q.size() != 0) n_fail = n_fail + 1;
        end_of_test;
    end
endmodule
`default_nettype wire
